// ===== hw/flash_prot_pkg.sv
package flash_prot_pkg;

  // bus timing at the 40 MHz system clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WRITE_NS = 70;
  localparam int T_READ_NS = 110;
  localparam int T_UNLOCK_GAP_NS = 6000;
  localparam logic [8:0] WR_CYC = 9'((T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] RD_CYC = 9'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] GAP_CYC = 9'((T_UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_TADDR = 8'h08;
  localparam logic [7:0] REG_TDATA = 8'h0C;
  localparam logic [7:0] REG_PW_LO = 8'h10;
  localparam logic [7:0] REG_PW_HI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RDATA = 8'h1C;
  localparam logic [7:0] REG_PWRD_LO = 8'h20;
  localparam logic [7:0] REG_PWRD_HI = 8'h24;

  // field positions and reset values
  localparam int CFG_X8_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_DATA_BIT = 2;
  localparam int ST_MODE_LSB = 4;
  localparam logic CFG_X8_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // command cycle data and addresses
  localparam logic [7:0] CODE_UNLK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLK2 = 8'h55;
  localparam logic [7:0] CODE_LOCKREG = 8'h40;
  localparam logic [7:0] CODE_PASSWORD = 8'h60;
  localparam logic [7:0] CODE_NVPROT = 8'hC0;
  localparam logic [7:0] CODE_NVLOCK = 8'h50;
  localparam logic [7:0] CODE_VOLATILE = 8'hE0;
  localparam logic [7:0] CODE_EXTBLK = 8'h88;
  localparam logic [7:0] CODE_EXIT = 8'h90;
  localparam logic [7:0] CODE_EXIT2 = 8'h00;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_PW1 = 8'h25;
  localparam logic [7:0] CODE_PW2 = 8'h03;
  localparam logic [7:0] CODE_PWEND = 8'h29;
  localparam logic [7:0] CODE_CLR1 = 8'h80;
  localparam logic [7:0] CODE_CLR2 = 8'h30;
  localparam logic [7:0] BIT_PROTECTED = 8'h00;
  localparam logic [7:0] BIT_UNPROTECTED = 8'h01;
  localparam logic [26:0] ADDR1_X8 = 27'hAAA;
  localparam logic [26:0] ADDR2_X8 = 27'h555;
  localparam logic [26:0] ADDR1_X16 = 27'h555;
  localparam logic [26:0] ADDR2_X16 = 27'h2AA;
  localparam logic [3:0] UNLOCK_LAST_X8 = 4'hA;
  localparam logic [3:0] UNLOCK_LAST_X16 = 4'h6;
  localparam logic [3:0] PW_LAST_X8 = 4'h7;
  localparam logic [3:0] PW_LAST_X16 = 4'h3;

  typedef enum logic [3:0] {
    OP_ENTER_LOCKREG = 4'h0, OP_ENTER_PASSWORD = 4'h1, OP_ENTER_NVPROT = 4'h2,
    OP_ENTER_NVLOCK = 4'h3, OP_ENTER_VOLATILE = 4'h4, OP_ENTER_EXTBLK = 4'h5,
    OP_EXIT_SET = 4'h6, OP_EXIT_EXT = 4'h7, OP_PROGRAM = 4'h8, OP_PROTECT = 4'h9,
    OP_UNPROTECT = 4'hA, OP_READ = 4'hB, OP_READ_PW = 4'hC, OP_UNLOCK = 4'hD,
    OP_CLEAR_ALL = 4'hE, OP_PROG_EXT = 4'hF
  } op_t;

  typedef enum logic [2:0] {
    MODE_NONE = 3'h0, MODE_LOCKREG = 3'h1, MODE_PASSWORD = 3'h2, MODE_NVPROT = 3'h3,
    MODE_NVLOCK = 3'h4, MODE_VOLATILE = 3'h5, MODE_EXTBLK = 3'h6
  } mode_t;

  typedef struct packed {
    logic last;
    logic rd;
    logic [26:0] a;
    logic [15:0] d;
  } step_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [25:0] addr;
    logic lowest_byte_address_bit;
    logic [15:0] dq_o;
  } flash_out_t;

  localparam flash_out_t FLASH_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                                        addr: 26'h0, lowest_byte_address_bit: 1'b0,
                                        dq_o: 16'h0};

endpackage

// ===== hw/flash_prot_host.sv
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// RQ1 - enter a protection set before protection commands
// RQ2 - set persists until 90h then 00h exit
// RQ3 - upper data and address bits ignored in commands
// RQ4 - register and password reads are plain reads
// RQ5 - status reads are read cycles, bit on DQ0
// RQ6 - one password portion per program sequence
// RQ7 - password portions accepted in any order
// RQ8 - x8 password read: byte n at address n
// RQ9 - unlock: 25h, 03h, pairs, 29h; 11/7 cycles
// RQ10 - protection bit data: 00 protected, 01 unprotected
// RQ11 - clear-all programs all bits before erasing
// RQ12 - lock set redirects accesses to lock register
// RQ13 - A0h plus data programs lock register
// RQ14 - password set accepts program, read, unlock
// RQ15 - portion selected by A1:A0 plus byte bit
// RQ16 - erased password reads all ones
// RQ17 - locked password mode reads back 00h
// RQ18 - correct password clears nonvolatile lock bit
// RQ19 - at least 6 us between unlock commands
// RQ20 - allow 6 us for unlock to complete
// RQ21 - nonvolatile set accepts program, status, clear-all
// RQ22 - A0h with block address protects that block
// RQ23 - nonvolatile bit overrides volatile bit
// RQ24 - extended block mapped at block 0, no erase
// RQ25 - clear-all needs no address, fails when locked
// RQ26 - mismatched write aborts sequence, mode kept
module flash_prot_host
  import flash_prot_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output flash_out_t flash_o,
  input wire logic [15:0] flash_dq_i
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_ADDR = 6'b000010, ST_SETUP = 6'b000100,
    ST_PULSE = 6'b001000, ST_HOLD = 6'b010000, ST_WAIT = 6'b100000
  } st_t;

  st_t st_r;
  op_t op_r;
  mode_t mode_r;
  flash_out_t flash_r;
  logic [3:0] idx_r;
  logic [8:0] cnt_r;
  logic cfg_x8_r, refused_r;
  logic [26:0] taddr_r;
  logic [15:0] tdata_r, rdata_r;
  logic [63:0] pw_r, pwrd_r;
  logic aw_have_r, w_have_r, bvalid_r, arready_r, rvalid_r, awready_r, wready_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, rdata_out_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, cmd_wr, start_ok, start_go;
  step_t cur;

  // merge written bytes into a register value
  function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] val,
                                             logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i]) r[i*8 +: 8] = val[i*8 +: 8];
    end
    return r;
  endfunction

  // true when the register offset is mapped
  function automatic logic reg_mapped(logic [7:0] a);
    return (a == REG_CMD) || (a == REG_CFG) || (a == REG_TADDR) || (a == REG_TDATA) ||
           (a == REG_PW_LO) || (a == REG_PW_HI) || (a == REG_STATUS) || (a == REG_RDATA) ||
           (a == REG_PWRD_LO) || (a == REG_PWRD_HI);
  endfunction

  // an operation may only start in the set it belongs to
  function automatic logic op_ok(op_t op, mode_t m);
    case (op)
      OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NVPROT,
      OP_ENTER_NVLOCK, OP_ENTER_VOLATILE, OP_ENTER_EXTBLK: return m == MODE_NONE; // [RQ2]
      OP_EXIT_SET: return (m != MODE_NONE) && (m != MODE_EXTBLK);
      OP_EXIT_EXT: return m == MODE_EXTBLK;
      OP_PROGRAM: return m inside {MODE_LOCKREG, MODE_PASSWORD, MODE_NVLOCK}; // [RQ1] [RQ13]
      OP_PROTECT: return m inside {MODE_NVPROT, MODE_VOLATILE}; // [RQ1]
      OP_UNPROTECT: return m == MODE_VOLATILE;
      OP_READ: return 1'b1;
      OP_READ_PW, OP_UNLOCK: return m == MODE_PASSWORD; // [RQ14]
      OP_CLEAR_ALL: return m == MODE_NVPROT; // [RQ21]
      OP_PROG_EXT: return m == MODE_EXTBLK;
      default: return 1'b0;
    endcase
  endfunction

  // set that the device stands in after an operation
  function automatic mode_t mode_after(op_t op, mode_t m);
    case (op)
      OP_ENTER_LOCKREG: return MODE_LOCKREG;
      OP_ENTER_PASSWORD: return MODE_PASSWORD;
      OP_ENTER_NVPROT: return MODE_NVPROT;
      OP_ENTER_NVLOCK: return MODE_NVLOCK;
      OP_ENTER_VOLATILE: return MODE_VOLATILE;
      OP_ENTER_EXTBLK: return MODE_EXTBLK;
      OP_EXIT_SET, OP_EXIT_EXT: return MODE_NONE; // [RQ2]
      default: return m;
    endcase
  endfunction

  // entry code of each command set
  function automatic logic [7:0] enter_code(op_t op);
    case (op)
      OP_ENTER_LOCKREG: return CODE_LOCKREG;
      OP_ENTER_PASSWORD: return CODE_PASSWORD;
      OP_ENTER_NVPROT: return CODE_NVPROT;
      OP_ENTER_NVLOCK: return CODE_NVLOCK;
      OP_ENTER_VOLATILE: return CODE_VOLATILE;
      default: return CODE_EXTBLK;
    endcase
  endfunction

  // address, data and direction of bus cycle idx of an operation
  function automatic step_t step_f(op_t op, logic [3:0] idx, logic x8, logic [26:0] ta,
                                   logic [15:0] td, logic [63:0] pw);
    step_t s;
    logic [26:0] a1, a2;
    logic [3:0] p;
    s = '0;
    a1 = x8 ? ADDR1_X8 : ADDR1_X16;
    a2 = x8 ? ADDR2_X8 : ADDR2_X16;
    p = (op == OP_UNLOCK) ? 4'(idx - 4'h2) : idx;
    case (op)
      OP_ENTER_LOCKREG, OP_ENTER_PASSWORD, OP_ENTER_NVPROT,
      OP_ENTER_NVLOCK, OP_ENTER_VOLATILE, OP_ENTER_EXTBLK:
        if (idx == 4'h0) s = '{1'b0, 1'b0, a1, {8'h00, CODE_UNLK1}};
        else if (idx == 4'h1) s = '{1'b0, 1'b0, a2, {8'h00, CODE_UNLK2}};
        else s = '{1'b1, 1'b0, a1, {8'h00, enter_code(op)}};
      OP_EXIT_SET: // [RQ2]
        if (idx == 4'h0) s = '{1'b0, 1'b0, 27'h0, {8'h00, CODE_EXIT}};
        else s = '{1'b1, 1'b0, 27'h0, {8'h00, CODE_EXIT2}};
      OP_EXIT_EXT:
        if (idx == 4'h0) s = '{1'b0, 1'b0, a1, {8'h00, CODE_UNLK1}};
        else if (idx == 4'h1) s = '{1'b0, 1'b0, a2, {8'h00, CODE_UNLK2}};
        else if (idx == 4'h2) s = '{1'b0, 1'b0, a2, {8'h00, CODE_EXIT}};
        else s = '{1'b1, 1'b0, 27'h0, {8'h00, CODE_EXIT2}};
      OP_PROGRAM, OP_PROTECT, OP_UNPROTECT: // [RQ6] [RQ13]
        if (idx == 4'h0) s = '{1'b0, 1'b0, 27'h0, {8'h00, CODE_PROG}};
        else if (op == OP_PROTECT) s = '{1'b1, 1'b0, ta, {8'h00, BIT_PROTECTED}}; // [RQ10]
        else if (op == OP_UNPROTECT) s = '{1'b1, 1'b0, ta, {8'h00, BIT_UNPROTECTED}};
        else s = '{1'b1, 1'b0, ta, td};
      OP_READ: s = '{1'b1, 1'b1, ta, 16'h0}; // [RQ4] [RQ5]
      OP_READ_PW: // [RQ8] [RQ15]
        s = '{idx == (x8 ? PW_LAST_X8 : PW_LAST_X16), 1'b1, {23'h0, idx}, 16'h0};
      OP_UNLOCK: // [RQ9]
        if (idx == 4'h0) s = '{1'b0, 1'b0, 27'h0, {8'h00, CODE_PW1}};
        else if (idx == 4'h1) s = '{1'b0, 1'b0, 27'h0, {8'h00, CODE_PW2}};
        else if (idx == (x8 ? UNLOCK_LAST_X8 : UNLOCK_LAST_X16))
          s = '{1'b1, 1'b0, 27'h0, {8'h00, CODE_PWEND}};
        else if (x8) s = '{1'b0, 1'b0, {23'h0, p}, {8'h00, pw[p[2:0]*8 +: 8]}};
        else s = '{1'b0, 1'b0, {23'h0, p}, pw[p[1:0]*16 +: 16]};
      OP_CLEAR_ALL: // [RQ25]
        if (idx == 4'h0) s = '{1'b0, 1'b0, 27'h0, {8'h00, CODE_CLR1}};
        else s = '{1'b1, 1'b0, 27'h0, {8'h00, CODE_CLR2}};
      OP_PROG_EXT:
        if (idx == 4'h0) s = '{1'b0, 1'b0, a1, {8'h00, CODE_UNLK1}};
        else if (idx == 4'h1) s = '{1'b0, 1'b0, a2, {8'h00, CODE_UNLK2}};
        else if (idx == 4'h2) s = '{1'b0, 1'b0, a1, {8'h00, CODE_PROG}};
        else s = '{1'b1, 1'b0, ta, td};
      default: s = '{1'b1, 1'b1, 27'h0, 16'h0};
    endcase
    return s;
  endfunction

  // current bus cycle and register write decode
  assign cur = step_f(op_r, idx_r, cfg_x8_r, taddr_r, tdata_r, pw_r);
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign cmd_wr = wr_fire && (waddr_r == REG_CMD) && wstrb_r[0];
  assign start_ok = (st_r == ST_IDLE) && op_ok(op_t'(wdata_r[3:0]), mode_r); // [RQ1]
  assign start_go = cmd_wr && start_ok;

  // write address and data channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_r)
      begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (reg_mapped(waddr_r) && waddr_r != REG_STATUS ? RESP_OKAY : RESP_SLVERR);
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // software registers; a refusal in the same cycle as its clear wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_x8_r <= CFG_X8_RESET;
      taddr_r <= 27'h0;
      tdata_r <= 16'h0;
      pw_r <= 64'h0;
      refused_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_fire && waddr_r == REG_CFG && wstrb_r[0]) cfg_x8_r <= wdata_r[CFG_X8_BIT];
      if (wr_fire && waddr_r == REG_TADDR)
        taddr_r <= 27'(apply_strb({5'h0, taddr_r}, wdata_r, wstrb_r));
      if (wr_fire && waddr_r == REG_TDATA)
        tdata_r <= 16'(apply_strb({16'h0, tdata_r}, wdata_r, wstrb_r));
      if (wr_fire && waddr_r == REG_PW_LO) pw_r[31:0] <= apply_strb(pw_r[31:0], wdata_r, wstrb_r);
      if (wr_fire && waddr_r == REG_PW_HI)
        pw_r[63:32] <= apply_strb(pw_r[63:32], wdata_r, wstrb_r);
      if (cmd_wr && !start_ok) refused_r <= 1'b1;
      else if (wr_fire && waddr_r == REG_RDATA && wstrb_r[0] && wdata_r[ST_REFUSED_BIT])
        refused_r <= 1'b0;
    end
  end

  // read channel, answered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_out_r <= 32'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && arready_r)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= reg_mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          REG_CFG: rdata_out_r <= {31'h0, cfg_x8_r};
          REG_TADDR: rdata_out_r <= {5'h0, taddr_r};
          REG_TDATA: rdata_out_r <= {16'h0, tdata_r};
          REG_PW_LO: rdata_out_r <= pw_r[31:0];
          REG_PW_HI: rdata_out_r <= pw_r[63:32];
          REG_STATUS: rdata_out_r <= {25'h0, mode_r, 1'b0, rdata_r[0], refused_r, // [RQ5]
                                      st_r != ST_IDLE};
          REG_RDATA: rdata_out_r <= {16'h0, rdata_r};
          REG_PWRD_LO: rdata_out_r <= pwrd_r[31:0];
          REG_PWRD_HI: rdata_out_r <= pwrd_r[63:32];
          default: rdata_out_r <= 32'h0;
        endcase
      end
      else if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // flash bus sequencer: address, strobe, hold for every cycle of an operation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ST_IDLE;
      op_r <= OP_READ;
      mode_r <= MODE_NONE;
      idx_r <= 4'h0;
      cnt_r <= 9'h000;
      flash_r <= FLASH_IDLE;
      rdata_r <= 16'h0;
      pwrd_r <= 64'h0;
    end
    else if (clk_en)
    begin
      case (st_r)
        ST_IDLE:
          if (start_go)
          begin
            op_r <= op_t'(wdata_r[3:0]);
            idx_r <= 4'h0;
            st_r <= ST_ADDR;
          end
        ST_ADDR:
        begin
          flash_r.ce_n <= 1'b0;
          flash_r.dq_oe_n <= cur.rd; // [RQ5]
          flash_r.addr <= cfg_x8_r ? cur.a[26:1] : cur.a[25:0]; // [RQ15]
          flash_r.lowest_byte_address_bit <= cfg_x8_r & cur.a[0];
          flash_r.dq_o <= cfg_x8_r ? {8'h00, cur.d[7:0]} : cur.d; // [RQ3]
          st_r <= ST_SETUP;
        end
        ST_SETUP:
        begin
          flash_r.oe_n <= !cur.rd; // [RQ4]
          flash_r.we_n <= cur.rd;
          cnt_r <= (cur.rd ? RD_CYC : WR_CYC) - 9'h001;
          st_r <= ST_PULSE;
        end
        ST_PULSE:
          if (cnt_r == 9'h000)
          begin
            flash_r.oe_n <= 1'b1;
            flash_r.we_n <= 1'b1;
            if (cur.rd) rdata_r <= cfg_x8_r ? {8'h00, flash_dq_i[7:0]} : flash_dq_i;
            if (op_r == OP_READ_PW && cfg_x8_r) pwrd_r[idx_r[2:0]*8 +: 8] <= flash_dq_i[7:0];
            else if (op_r == OP_READ_PW) pwrd_r[idx_r[1:0]*16 +: 16] <= flash_dq_i; // [RQ8]
            st_r <= ST_HOLD;
          end
          else cnt_r <= cnt_r - 9'h001;
        ST_HOLD:
        begin
          flash_r.ce_n <= 1'b1;
          flash_r.dq_oe_n <= 1'b1;
          if (!cur.last)
          begin
            idx_r <= idx_r + 4'h1;
            st_r <= ST_ADDR;
          end
          else
          begin
            mode_r <= mode_after(op_r, mode_r); // [RQ2]
            if (op_r == OP_UNLOCK)
            begin
              cnt_r <= GAP_CYC - 9'h001; // [RQ19] [RQ20]
              st_r <= ST_WAIT;
            end
            else st_r <= ST_IDLE;
          end
        end
        ST_WAIT:
          if (cnt_r == 9'h000) st_r <= ST_IDLE; // [RQ19]
          else cnt_r <= cnt_r - 9'h001;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ports straight from flip-flops
  assign flash_o = flash_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_out_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // sequence checks
  chk_set_before_prot: assert property ((st_r == ST_ADDR) && (op_r inside {OP_PROGRAM, // [RQ1]
      OP_PROTECT, OP_UNPROTECT, OP_UNLOCK, OP_CLEAR_ALL}) |-> mode_r != MODE_NONE)
    else $error("protection command outside a set");
  chk_exit_codes: assert property ((st_r == ST_PULSE) && (op_r == OP_EXIT_SET) |-> // [RQ2]
      flash_r.dq_o[7:0] == ((idx_r == 4'h0) ? CODE_EXIT : CODE_EXIT2))
    else $error("exit sequence data wrong");
  chk_exit_mode: assert property (clk_en && (st_r == ST_HOLD) && (op_r == OP_EXIT_SET) && // [RQ2]
      cur.last |=> (mode_r == MODE_NONE) && (st_r == ST_IDLE))
    else $error("exit did not return to no set");
  chk_read_cycle: assert property ((st_r == ST_PULSE) && (op_r inside {OP_READ, // [RQ5]
      OP_READ_PW}) |-> !flash_r.oe_n && flash_r.we_n && flash_r.dq_oe_n)
    else $error("read step not a bus read");
  chk_oe_in_ce: assert property (!flash_r.oe_n |-> !flash_r.ce_n && flash_r.we_n) // [RQ4]
    else $error("output enable outside chip select");
  chk_unlock_lead: assert property ((st_r == ST_PULSE) && (op_r == OP_UNLOCK) && // [RQ9]
      (idx_r < 4'h2) |-> flash_r.dq_o[7:0] == ((idx_r == 4'h0) ? CODE_PW1 : CODE_PW2))
    else $error("unlock lead codes wrong");
  chk_unlock_len: assert property ((st_r == ST_HOLD) && (op_r == OP_UNLOCK) && cur.last // [RQ9]
      |-> idx_r == (cfg_x8_r ? UNLOCK_LAST_X8 : UNLOCK_LAST_X16))
    else $error("unlock cycle count wrong");
  chk_gap_load: assert property (clk_en && (st_r == ST_HOLD) && (op_r == OP_UNLOCK) && // [RQ19]
      cur.last |=> (st_r == ST_WAIT) && (cnt_r == GAP_CYC - 9'h001))
    else $error("unlock gap not started");
  chk_gap_hold: assert property (clk_en && (st_r == ST_WAIT) && (cnt_r != 9'h000) |=> // [RQ20]
      (st_r == ST_WAIT) && (cnt_r == $past(cnt_r) - 9'h001))
    else $error("unlock gap cut short");
  chk_pw_addr: assert property ((st_r == ST_PULSE) && (op_r == OP_READ_PW) |-> // [RQ8] [RQ15]
      (cfg_x8_r ? ({flash_r.addr[1:0], flash_r.lowest_byte_address_bit} == idx_r[2:0])
                : (flash_r.addr[1:0] == idx_r[1:0])) && (flash_r.addr[25:2] == 24'h0))
    else $error("password portion address wrong");
  chk_prog_code: assert property ((st_r == ST_PULSE) && (op_r == OP_PROGRAM) && // [RQ6] [RQ13]
      (idx_r == 4'h0) |-> !flash_r.we_n && (flash_r.dq_o[7:0] == CODE_PROG))
    else $error("program lead code wrong");

  cov_unlock_done: cover property ((st_r == ST_WAIT) && (cnt_r == 9'h000));
  cov_pw_read: cover property ((st_r == ST_HOLD) && (op_r == OP_READ_PW) && cur.last);
  cov_exit: cover property ((st_r == ST_HOLD) && (op_r == OP_EXIT_SET) && cur.last);
  cov_refused: cover property (cmd_wr && !start_ok);

endmodule // flash_prot_host

// ===== tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
  import flash_prot_pkg::*;
(
  input wire flash_out_t f,
  output logic [15:0] dq
);
  logic [7:0] mode_r = 8'h00;
  logic [7:0] h1_r = 8'h00;
  logic [7:0] h2_r = 8'h00;
  logic [7:0] wd_r = 8'h00;
  logic [15:0] lock_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] pw_r [4] = '{default: 16'hFFFF};
  logic [15:0] rd_w;
  int nwr = 0;
  int nclr = 0;
  // command decode at the rising write strobe, upper data byte ignored
  always @(posedge f.we_n)
  begin
    if (!f.ce_n)
    begin
      nwr <= nwr + 1;
      wd_r <= f.dq_o[7:0];
      h1_r <= f.dq_o[7:0];
      h2_r <= h1_r;
      if (mode_r == 8'h00 && h2_r == CODE_UNLK1 && h1_r == CODE_UNLK2)
        mode_r <= f.dq_o[7:0];
      else if (h1_r == CODE_EXIT && f.dq_o[7:0] == CODE_EXIT2)
        mode_r <= 8'h00;
      else if (h1_r == CODE_PROG && mode_r == CODE_LOCKREG)
        lock_r <= f.dq_o;
      else if (h1_r == CODE_PROG && mode_r == CODE_PASSWORD)
        pw_r[f.addr[1:0]] <= f.dq_o;
      else if (mode_r == CODE_NVPROT && h1_r == CODE_CLR1 && f.dq_o[7:0] == CODE_CLR2)
        nclr <= nclr + 1;
    end
  end
  // keep the last driven value to invert it once released
  always @(posedge f.oe_n)
    last_r <= rd_w;
  // plain reads return the addressed content, upper byte on the byte bit in x8
  always_comb
  begin
    rd_w = (mode_r == CODE_LOCKREG) ? lock_r :
           (mode_r == CODE_PASSWORD) ? pw_r[f.addr[1:0]] : f.addr[15:0];
    if (f.lowest_byte_address_bit) rd_w = {8'h00, rd_w[15:8]};
    if (!f.ce_n && !f.oe_n) dq = rd_w;
    else dq = ~last_r;
  end
endmodule // flash_dev_model

// ===== tb/flash_prot_host_tb.sv
`timescale 1ns/1ps
module flash_prot_host_tb;
  import flash_prot_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, br;
  logic [15:0] dq;
  flash_out_t fo;
  int errors, n_tests, nw;
  realtime t0;
  logic [7:0] codes [6] = '{CODE_LOCKREG, CODE_PASSWORD, CODE_NVPROT, CODE_NVLOCK,
                            CODE_VOLATILE, CODE_EXTBLK};
  flash_prot_host u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_o(fo), .flash_dq_i(dq));
  flash_dev_model u_dev (.f(fo), .dq(dq));
  // clock and watchdog
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial
  begin
    #2000000;
    errors = errors + 1;
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    br = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input logic [3:0] op);
    axw(REG_CMD, {28'h0, op});
    do axr(REG_STATUS); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  // reset, then the test sequence
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_CFG);
    chk("cfg reset", {31'h0, CFG_X8_RESET}, rd);
    axr(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], br});
    axw(REG_STATUS, 32'h0);
    chk("status write", {30'h0, RESP_SLVERR}, {30'h0, br});
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      run(4'(i));
      axr(REG_STATUS);
      chk("mode", 32'(i + 1), {29'h0, rd[6:4]});
      chk("dev mode", {24'h0, codes[i]}, {24'h0, u_dev.mode_r});
      run(i == 5 ? 4'h7 : 4'h6);
      chk("dev exit", 32'h0, {24'h0, u_dev.mode_r});
    end
    $display("test enter exit done");
    axw(REG_TDATA, 32'h1234);
    run(4'h0);
    run(4'h8);
    run(4'hB);
    axr(REG_RDATA);
    chk("lock reg", 32'h1234, rd);
    run(4'h6);
    run(4'h1);
    run(4'hC);
    axr(REG_PWRD_LO);
    chk("pw erased", 32'hFFFFFFFF, rd);
    axw(REG_TADDR, 32'h2);
    axw(REG_TDATA, 32'hBEEF);
    run(4'h8);
    run(4'hC);
    axr(REG_PWRD_HI);
    chk("pw word2", 32'hFFFFBEEF, rd);
    $display("test lock and password done");
    axw(REG_PW_LO, 32'h01020304);
    axw(REG_PW_HI, 32'h05060708);
    nw = u_dev.nwr;
    t0 = $realtime;
    axw(REG_CMD, 32'hD);
    axw(REG_CMD, 32'hD);
    do axr(REG_STATUS); while (rd[ST_BUSY_BIT] !== 1'b0);
    chk("unlock gap", 32'h1, {31'h0, ($realtime - t0) >= real'(T_UNLOCK_GAP_NS + 42 * CLK_PERIOD_NS)});
    chk("unlock cycles", 32'd7, 32'(u_dev.nwr - nw));
    chk("unlock end", {24'h0, CODE_PWEND}, {24'h0, u_dev.wd_r});
    chk("refused", 32'h1, {31'h0, rd[ST_REFUSED_BIT]});
    axw(REG_RDATA, 32'h2);
    run(4'h9);
    chk("wrong set", 32'h1, {31'h0, rd[ST_REFUSED_BIT]});
    axw(REG_RDATA, 32'h2);
    axr(REG_STATUS);
    chk("refused clear", 32'h0, {31'h0, rd[ST_REFUSED_BIT]});
    axw(REG_CFG, 32'h1);
    nw = u_dev.nwr;
    run(4'hD);
    chk("unlock x8", 32'd11, 32'(u_dev.nwr - nw));
    run(4'hC);
    axr(REG_PWRD_HI);
    chk("pw x8", 32'hFFFFBEEF, rd);
    axw(REG_CFG, 32'h0);
    run(4'h6);
    $display("test unlock done");
    run(4'h2);
    axw(REG_TADDR, 32'h20000);
    run(4'h9);
    chk("nv protect", {24'h0, BIT_PROTECTED}, {24'h0, u_dev.wd_r});
    nw = u_dev.nwr;
    run(4'hE);
    chk("clear all", 32'd2, 32'(u_dev.nwr - nw));
    chk("clear code", {24'h0, CODE_CLR2}, {24'h0, u_dev.wd_r});
    chk("clear seen", 32'd1, 32'(u_dev.nclr));
    run(4'h6);
    run(4'h4);
    run(4'hA);
    chk("vol clear", {24'h0, BIT_UNPROTECTED}, {24'h0, u_dev.wd_r});
    run(4'h6);
    $display("test protection bits done");
    results();
  end
endmodule // flash_prot_host_tb
